// ==== net_packet_header_offload_tb.sv ====
// self-checking testbench for the packet header offload block
`timescale 1ns/1ps
`default_nettype none
module net_packet_header_offload_tb;
  import nph_pkg::*;
  logic clk_sys, sys_rst, rx_start, tx_valid, tx_last, tx_hdr_valid, tx_needs_csum, tx_csum_ok;
  logic tx_hdr_len_exact, tx_csum_done, rx_busy, rx_hdr_valid, rx_hdr_last;
  logic [9:0] feat;
  logic [7:0] tx_data, tx_gso_type, rx_hdr_byte, rx_gso;
  logic [15:0] tx_gso_size, tx_hdr_len, tx_csum_value, tx_csum_pos, rx_hlen, rx_cst, rx_cof;
  logic [15:0] rx_bufs, cap_gsz;
  logic ce, rx_dv;
  logic cap_needs, cap_exact, cap_ok, cap_done;
  logic [7:0] cap_gso;
  logic [15:0] cap_hlen, cap_val, cap_pos;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  nph_drv_model i_drv (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last));
  nph_top #(.MAX_HDR_LEN(16'h0100)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .feat_csum(feat[0]), .feat_host_gso(feat[1]), .feat_hdrlen(feat[2]),
    .feat_guest_csum(feat[3]), .feat_guest_tso4(feat[4]), .feat_guest_tso6(feat[5]),
    .feat_guest_ufo(feat[6]), .feat_guest_ecn(feat[7]), .feat_mrg_rxbuf(feat[8]),
    .feat_rsc_ext(feat[9]), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_hdr_valid(tx_hdr_valid), .tx_needs_csum(tx_needs_csum), .tx_csum_ok(tx_csum_ok),
    .tx_gso_type(tx_gso_type), .tx_gso_size(tx_gso_size), .tx_hdr_len(tx_hdr_len),
    .tx_hdr_len_exact(tx_hdr_len_exact), .tx_csum_done(tx_csum_done),
    .tx_csum_value(tx_csum_value), .tx_csum_pos(tx_csum_pos), .rx_start(rx_start),
    .rx_needs_csum(1'b1), .rx_data_valid(rx_dv), .rx_gso_type(rx_gso),
    .rx_gso_size(16'h05DC), .rx_hdr_len(rx_hlen), .rx_csum_start(rx_cst),
    .rx_csum_offset(rx_cof), .rx_coalesced(16'h0007), .rx_dup_acks(16'h0002),
    .rx_buf_count(rx_bufs), .rx_busy(rx_busy), .rx_hdr_valid(rx_hdr_valid),
    .rx_hdr_byte(rx_hdr_byte), .rx_hdr_last(rx_hdr_last));
  always @(negedge clk_sys) begin
    if (tx_hdr_valid === 1'b1) begin
      cap_needs = tx_needs_csum;
      cap_gso   = tx_gso_type;
      cap_gsz   = tx_gso_size;
      cap_hlen  = tx_hdr_len;
      cap_exact = tx_hdr_len_exact;
      cap_ok    = tx_csum_ok;
    end
    if (tx_csum_done === 1'b1) begin
      cap_done = 1'b1;
      cap_val  = tx_csum_value;
      cap_ok   = tx_csum_ok;
    end
    cap_pos = tx_csum_pos;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // odd trailing byte lands in the high half with a zero low half
  function automatic logic [15:0] exp_csum(input int cst, input int blen);
    logic [31:0] acc;
    acc = 32'h0;
    for (int k = cst; k < blen; k++)
      acc += ((k - cst) % 2 == 0) ? {i_drv.body_byte(k), 8'h00} : {8'h00, i_drv.body_byte(k)};
    acc = acc[15:0] + acc[31:16];
    acc = acc[15:0] + acc[31:16];
    return ~acc[15:0];
  endfunction : exp_csum
  task automatic tx_pkt(input logic [7:0] fl, input logic [7:0] gso, input logic [15:0] hl,
                        input logic ex_exact);
    cap_done = 1'b0;
    i_drv.send(fl, gso, hl, 16'h0014, 16'h0006, 41);
    repeat (4) @(negedge clk_sys);
    check("needs_csum", 16'(cap_needs), 16'(fl[0]));
    check("gso_type", 16'(cap_gso), 16'(gso));
    check("gso_size", cap_gsz, 16'h05B4);
    check("hdr_len", cap_hlen, hl);
    check("hdr_len_exact", 16'(cap_exact), 16'(ex_exact));
    check("csum_done", 16'(cap_done), 16'(fl[0]));
    check("csum_ok", 16'(cap_ok), 16'(fl[0]));
    check("csum_pos", cap_pos, fl[0] ? 16'h001A : 16'h0000);
    if (fl[0]) check("csum_value", cap_val, exp_csum(20, 41));
    $display("test tx gso %h done", gso);
  endtask : tx_pkt
  task automatic rx_hdr(input logic [7:0] ex [12]);
    logic [7:0] got [12];
    int n;
    n = 0;
    @(negedge clk_sys);
    rx_start <= 1'b1;
    @(negedge clk_sys);
    rx_start <= 1'b0;
    for (int c = 0; c < 20 && n < 12; c++) begin
      @(negedge clk_sys);
      if (rx_hdr_valid === 1'b1) begin
        got[n] = rx_hdr_byte;
        n++;
      end
    end
    check("rx byte count", 16'(n), 16'h000C);
    for (int i = 0; i < n; i++) check("rx header byte", 16'(got[i]), 16'(ex[i]));
    $display("test rx header done");
  endtask : rx_hdr
  initial begin
    logic [7:0] codes [5];
    codes = '{{1'b0, NPH_GSO_NONE}, {1'b0, NPH_GSO_TCPV4}, {1'b0, NPH_GSO_UDP},
              {1'b0, NPH_GSO_TCPV6}, {1'b0, NPH_GSO_UDPL4}};
    sys_rst = 1'b1;
    ce = 1'b1;
    rx_dv = 1'b0;
    feat = 10'h007;
    rx_start = 1'b0;
    rx_gso = 8'h01;
    rx_hlen = 16'h0000;
    rx_cst = 16'h0000;
    rx_cof = 16'h0000;
    rx_bufs = 16'h0005;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    // bit 3 is unknown to the device; gso packets always ask for a checksum
    for (int i = 0; i < 5; i++)
      tx_pkt((i == 0) ? 8'h00 : 8'h09, codes[i], 16'h0036, i != 0);
    tx_pkt(8'h01, 8'h84, 16'h012C, 1'b0);
    tx_pkt(8'h01, 8'h01, 16'h000D, 1'b0);
    feat = 10'h003;
    tx_pkt(8'h01, 8'h04, 16'h0036, 1'b0);
    feat = 10'h001;
    tx_pkt(8'h00, 8'h00, 16'h0036, 1'b0);
    rx_hdr('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
             8'h01, 8'h00});
    feat = 10'h318;
    rx_dv = 1'b1;
    rx_hlen = 16'h0036;
    rx_bufs = 16'h0003;
    rx_hdr('{8'h07, 8'h01, 8'h36, 8'h00, 8'hDC, 8'h05, 8'h07, 8'h00, 8'h02, 8'h00,
             8'h03, 8'h00});
    // no coalescing: csum fields pass through, ecn bit kept with guest ecn
    feat = 10'h0A8;
    rx_gso = 8'h84;
    rx_cst = 16'h0022;
    rx_cof = 16'h0010;
    rx_hdr('{8'h03, 8'h84, 8'h36, 8'h00, 8'hDC, 8'h05, 8'h22, 8'h00, 8'h10, 8'h00,
             8'h01, 8'h00});
    stop_test();
  end
endmodule : net_packet_header_offload_tb
bind nph_top nph_top_props #(.MAX_HDR_LEN(MAX_HDR_LEN)) i_props (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .feat_hdrlen(feat_hdrlen), .feat_mrg_rxbuf(feat_mrg_rxbuf),
  .tx_hdr_valid(tx_hdr_valid), .tx_needs_csum(tx_needs_csum), .tx_csum_ok(tx_csum_ok),
  .tx_gso_type(tx_gso_type), .tx_hdr_len(tx_hdr_len), .tx_hdr_len_exact(tx_hdr_len_exact),
  .tx_csum_done(tx_csum_done), .rx_start(rx_start), .rx_buf_count(rx_buf_count),
  .rx_busy(rx_busy), .rx_hdr_valid(rx_hdr_valid), .rx_hdr_byte(rx_hdr_byte),
  .rx_hdr_last(rx_hdr_last));
`default_nettype wire

// ==== nph_drv_model.sv ====
// guest driver model that streams transmit packets into the block
`timescale 1ns/1ps
`default_nettype none
module nph_drv_model (
  input  wire logic       clk_sys,  // system clock
  output logic            tx_valid, // byte strobe
  output logic      [7:0] tx_data,  // byte
  output logic            tx_last   // last byte of packet
);
  initial begin
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    tx_last  = 1'b0;
  end
  function automatic logic [7:0] body_byte(input int i);
    return 8'(8'h3C + 7 * i);
  endfunction : body_byte
  // callers keep the driver's header obligations: flags, gso codes and sizes
  task automatic send(input logic [7:0] fl, input logic [7:0] gso, input logic [15:0] hlen,
                      input logic [15:0] cst, input logic [15:0] cof, input int blen);
    logic [7:0] hdr [12];
    hdr = '{fl, gso, hlen[7:0], hlen[15:8], 8'hB4, 8'h05, cst[7:0], cst[15:8],
            cof[7:0], cof[15:8], 8'h00, 8'h00};
    for (int i = 0; i < 12 + blen; i++) begin
      @(negedge clk_sys);
      tx_valid <= 1'b1;
      tx_data  <= (i < 12) ? hdr[i] : body_byte(i - 12);
      tx_last  <= (i == 11 + blen);
    end
    @(negedge clk_sys);
    tx_valid <= 1'b0;
    tx_last  <= 1'b0;
    // released line must not keep showing the last byte
    tx_data  <= ~tx_data;
  endtask : send
endmodule : nph_drv_model
`default_nettype wire

// ==== nph_pkg.sv ====
// shared constants for the packet header offload block, plus its checksum accumulator
package nph_pkg;
  localparam int unsigned NPH_HDR_BYTES = 12;
  localparam logic [3:0]  NPH_HDR_LAST  = 4'hB;
  // header byte offsets (multi-byte fields little-endian)
  localparam logic [3:0]  NPH_OFS_FLAGS     = 4'h0;
  localparam logic [3:0]  NPH_OFS_GSO_TYPE  = 4'h1;
  localparam logic [3:0]  NPH_OFS_HDR_LEN   = 4'h2;
  localparam logic [3:0]  NPH_OFS_GSO_SIZE  = 4'h4;
  localparam logic [3:0]  NPH_OFS_CSUM_ST   = 4'h6;
  localparam logic [3:0]  NPH_OFS_CSUM_OFS  = 4'h8;
  localparam logic [3:0]  NPH_OFS_NUM_BUFS  = 4'hA;
  // flag bit positions
  localparam int unsigned NPH_FLAG_NEEDS_CSUM = 0;
  localparam int unsigned NPH_FLAG_DATA_VALID = 1;
  localparam int unsigned NPH_FLAG_RSC_INFO   = 2;
  // gso_type codes
  localparam logic [6:0]  NPH_GSO_NONE  = 7'h00;
  localparam logic [6:0]  NPH_GSO_TCPV4 = 7'h01;
  localparam logic [6:0]  NPH_GSO_UDP   = 7'h03;
  localparam logic [6:0]  NPH_GSO_TCPV6 = 7'h04;
  localparam logic [6:0]  NPH_GSO_UDPL4 = 7'h05;
  localparam int unsigned NPH_GSO_ECN_BIT = 7;
  // smallest credible header run (ethernet header) for the hdr_len guard
  localparam logic [15:0] NPH_MIN_HDR_LEN = 16'h000E;
  localparam logic [15:0] NPH_MAX_HDR_LEN = 16'h0100;
  localparam logic [15:0] NPH_ONE_BUF     = 16'h0001;
endpackage : nph_pkg

`timescale 1ns/1ps
`default_nettype none
module nph_csum_acc (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        sys_rst,   // sync reset
  input  wire logic        ce,        // clock enable
  input  wire logic        clr,       // restart the sum
  input  wire logic        add,       // add one byte
  input  wire logic        odd,       // byte is the low half of its word
  input  wire logic [7:0]  data,      // byte to add
  output logic      [15:0] sum        // running ones' complement sum
);
  logic [15:0] sum_d;
  logic [16:0] wide;

  always_comb begin
    wide  = {1'b0, sum} + (odd ? {9'h000, data} : {1'b0, data, 8'h00});
    sum_d = sum;
    if (clr) begin
      sum_d = 16'h0000;
    end else if (add) begin
      // end-around carry keeps the sum ones' complement
      sum_d = wide[15:0] + {15'h0000, wide[16]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sum <= 16'h0000;
    end else if (ce) begin
      sum <= sum_d;
    end
  end
endmodule : nph_csum_acc
`default_nettype wire

// ==== nph_top.sv ====
// device-side packet header parser (transmit) and header builder (receive)
// Overview of operation
// - device ignores flag bits it does not implement
// - needs-checksum clear means csum_start and csum_offset are unused
// - exact hdr_len may be trusted, but only after a sanity check
// - otherwise hdr_len is only a hint, never relied upon
// - needs-checksum clear means packet checksum is not assumed correct
// - receive num_buffers is the count of buffers used by the packet
// - without merging, num_buffers is always one
// - coalescing reporting puts counts in csum fields and sets its flag
// - device computes ones' complement checksum and places it at start plus offset
`timescale 1ns/1ps
`default_nettype none
module nph_top
  import nph_pkg::*;
#(
  parameter logic [15:0] MAX_HDR_LEN = NPH_MAX_HDR_LEN  // hdr_len guard ceiling
) (
  input  wire logic        clk_sys,         // 40 MHz system clock
  input  wire logic        sys_rst,         // sync reset, active high
  input  wire logic        ce,              // clock enable, freezes all state
  input  wire logic        feat_csum,       // host checksum offload negotiated
  input  wire logic        feat_host_gso,   // any host TSO4/TSO6/USO/UFO negotiated
  input  wire logic        feat_hdrlen,     // exact header length negotiated
  input  wire logic        feat_guest_csum, // guest checksum negotiated
  input  wire logic        feat_guest_tso4, // guest TSO4 negotiated
  input  wire logic        feat_guest_tso6, // guest TSO6 negotiated
  input  wire logic        feat_guest_ufo,  // guest UFO negotiated
  input  wire logic        feat_guest_ecn,  // guest ECN negotiated
  input  wire logic        feat_mrg_rxbuf,  // mergeable receive buffers negotiated
  input  wire logic        feat_rsc_ext,    // coalescing reporting negotiated
  input  wire logic        tx_valid,        // transmit byte present
  input  wire logic [7:0]  tx_data,         // transmit byte, header first
  input  wire logic        tx_last,         // last byte of packet
  output logic             tx_hdr_valid,    // pulse: header decoded
  output logic             tx_needs_csum,   // device must fill checksum
  output logic             tx_csum_ok,      // packet checksum may be trusted
  output logic      [7:0]  tx_gso_type,     // segmentation code with ecn bit
  output logic      [15:0] tx_gso_size,     // MSS
  output logic      [15:0] tx_hdr_len,      // header length as given
  output logic             tx_hdr_len_exact,// hdr_len usable as exact length
  output logic             tx_csum_done,    // pulse: checksum result ready
  output logic      [15:0] tx_csum_value,   // checksum to store
  output logic      [15:0] tx_csum_pos,     // packet offset of checksum field
  input  wire logic        rx_start,        // pulse: build a receive header
  input  wire logic        rx_needs_csum,   // packet left partially summed
  input  wire logic        rx_data_valid,   // checksum validated
  input  wire logic [7:0]  rx_gso_type,     // proposed gso code
  input  wire logic [15:0] rx_gso_size,     // MSS
  input  wire logic [15:0] rx_hdr_len,      // header length
  input  wire logic [15:0] rx_csum_start,   // checksum start
  input  wire logic [15:0] rx_csum_offset,  // checksum offset
  input  wire logic [15:0] rx_coalesced,    // coalesced segment count
  input  wire logic [15:0] rx_dup_acks,     // duplicate ACK count
  input  wire logic [15:0] rx_buf_count,    // buffers used by the packet
  output logic             rx_busy,         // header being emitted
  output logic             rx_hdr_valid,    // header byte present
  output logic      [7:0]  rx_hdr_byte,     // header byte
  output logic             rx_hdr_last      // last header byte
);
  typedef enum logic [0:0] {TX_HDR = 1'b0, TX_BODY = 1'b1} nph_tx_type;

  function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
    le16 = {hi, lo};
  endfunction : le16

  function automatic logic gso_is_none(input logic [7:0] code);
    gso_is_none = (code[6:0] == NPH_GSO_NONE);
  endfunction : gso_is_none

  // transmit parser state
  nph_tx_type  tx_st_q, tx_st_d;
  logic [3:0]  tx_idx_q, tx_idx_d;
  logic [7:0]  hdr_q [NPH_HDR_BYTES], hdr_d [NPH_HDR_BYTES];
  logic [15:0] pos_q, pos_d;
  logic [15:0] cstart_q, cstart_d;
  logic        done_pend_q, done_pend_d;
  logic        hdr_valid_d, needs_d, ok_d, exact_d, done_d;
  logic [7:0]  gso_d;
  logic [15:0] gsz_d, hlen_d, cval_d, cpos_d;
  logic [15:0] f_hlen, f_cst, f_cofs;
  logic [7:0]  f_flags;
  logic        acc_clr, acc_add, acc_odd;
  logic [15:0] acc_sum, rel;

  assign f_flags = hdr_d[NPH_OFS_FLAGS];
  assign f_hlen  = le16(hdr_d[NPH_OFS_HDR_LEN], hdr_d[NPH_OFS_HDR_LEN + 4'h1]);
  assign f_cst   = le16(hdr_d[NPH_OFS_CSUM_ST], hdr_d[NPH_OFS_CSUM_ST + 4'h1]);
  assign f_cofs  = le16(hdr_d[NPH_OFS_CSUM_OFS], hdr_d[NPH_OFS_CSUM_OFS + 4'h1]);
  assign rel     = pos_q - cstart_q;

  always_comb begin
    tx_st_d     = tx_st_q;
    tx_idx_d    = tx_idx_q;
    hdr_d       = hdr_q;
    pos_d       = pos_q;
    cstart_d    = cstart_q;
    done_pend_d = 1'b0;
    hdr_valid_d = 1'b0;
    needs_d     = tx_needs_csum;
    ok_d        = tx_csum_ok;
    exact_d     = tx_hdr_len_exact;
    gso_d       = tx_gso_type;
    gsz_d       = tx_gso_size;
    hlen_d      = tx_hdr_len;
    cval_d      = tx_csum_value;
    cpos_d      = tx_csum_pos;
    done_d      = 1'b0;
    acc_clr     = 1'b0;
    acc_add     = 1'b0;
    acc_odd     = rel[0];
    unique case (tx_st_q)
      TX_HDR: begin
        if (tx_valid) begin
          // num_buffers bytes are stored but never read on transmit
          hdr_d[tx_idx_q] = tx_data;
          tx_idx_d = tx_idx_q + 4'h1;
          if (tx_idx_q == NPH_HDR_LAST) begin
            tx_idx_d    = 4'h0;
            tx_st_d     = TX_BODY;
            pos_d       = 16'h0000;
            acc_clr     = 1'b1;
            hdr_valid_d = 1'b1;
            // only the needs-checksum bit is implemented here
            needs_d  = f_flags[NPH_FLAG_NEEDS_CSUM];
            ok_d     = 1'b0;
            gso_d    = hdr_d[NPH_OFS_GSO_TYPE];
            gsz_d    = le16(hdr_d[NPH_OFS_GSO_SIZE], hdr_d[NPH_OFS_GSO_SIZE + 4'h1]);
            hlen_d   = f_hlen;
            // a hostile hdr_len outside sane bounds falls back to hint status
            exact_d  = feat_host_gso && feat_hdrlen && !gso_is_none(hdr_d[NPH_OFS_GSO_TYPE])
                       && (f_hlen >= NPH_MIN_HDR_LEN) && (f_hlen <= MAX_HDR_LEN);
            // start and offset only latched when the flag asks for them
            cstart_d = f_flags[NPH_FLAG_NEEDS_CSUM] ? f_cst : 16'hFFFF;
            cpos_d   = f_flags[NPH_FLAG_NEEDS_CSUM] ? (f_cst + f_cofs) : 16'h0000;
            if (tx_last) begin
              tx_st_d = TX_HDR;
            end
          end
        end
      end
      TX_BODY: begin
        if (tx_valid) begin
          pos_d   = pos_q + 16'h0001;
          acc_add = tx_needs_csum && (pos_q >= cstart_q);
          if (tx_last) begin
            tx_st_d     = TX_HDR;
            done_pend_d = tx_needs_csum;
          end
        end
      end
    endcase
    if (done_pend_q) begin
      // sum starts from zero and covers only the body bytes from csum_start on
      cval_d = ~acc_sum;
      done_d = 1'b1;
      ok_d   = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st_q          <= TX_HDR;
      tx_idx_q         <= 4'h0;
      hdr_q            <= '{default: 8'h00};
      pos_q            <= 16'h0000;
      cstart_q         <= 16'hFFFF;
      done_pend_q      <= 1'b0;
      tx_hdr_valid     <= 1'b0;
      tx_needs_csum    <= 1'b0;
      tx_csum_ok       <= 1'b0;
      tx_gso_type      <= 8'h00;
      tx_gso_size      <= 16'h0000;
      tx_hdr_len       <= 16'h0000;
      tx_hdr_len_exact <= 1'b0;
      tx_csum_done     <= 1'b0;
      tx_csum_value    <= 16'h0000;
      tx_csum_pos      <= 16'h0000;
    end else if (ce) begin
      tx_st_q          <= tx_st_d;
      tx_idx_q         <= tx_idx_d;
      hdr_q            <= hdr_d;
      pos_q            <= pos_d;
      cstart_q         <= cstart_d;
      done_pend_q      <= done_pend_d;
      tx_hdr_valid     <= hdr_valid_d;
      tx_needs_csum    <= needs_d;
      tx_csum_ok       <= ok_d;
      tx_gso_type      <= gso_d;
      tx_gso_size      <= gsz_d;
      tx_hdr_len       <= hlen_d;
      tx_hdr_len_exact <= exact_d;
      tx_csum_done     <= done_d;
      tx_csum_value    <= cval_d;
      tx_csum_pos      <= cpos_d;
    end
  end

  nph_csum_acc u_acc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clr     (acc_clr),
    .add     (acc_add),
    .odd     (acc_odd),
    .data    (tx_data),
    .sum     (acc_sum)
  );

  // receive header builder
  logic [7:0]  rxh_q [NPH_HDR_BYTES], rxh_d [NPH_HDR_BYTES];
  logic [3:0]  rx_idx_q, rx_idx_d;
  logic        busy_d, rvalid_d, rlast_d;
  logic [7:0]  rbyte_d, r_flags, r_gso;
  logic [15:0] r_cst, r_cofs, r_nbuf;
  logic        r_gso_ok;

  always_comb begin
    // codes whose guest feature is missing are demoted to no segmentation
    unique case (rx_gso_type[6:0])
      NPH_GSO_TCPV4: r_gso_ok = feat_guest_tso4;
      NPH_GSO_TCPV6: r_gso_ok = feat_guest_tso6;
      NPH_GSO_UDP:   r_gso_ok = feat_guest_ufo;
      default:       r_gso_ok = 1'b0;
    endcase
    r_gso = r_gso_ok ? {rx_gso_type[NPH_GSO_ECN_BIT] & feat_guest_ecn, rx_gso_type[6:0]}
                     : {1'b0, NPH_GSO_NONE};
    r_flags = 8'h00;
    r_flags[NPH_FLAG_NEEDS_CSUM] = feat_guest_csum && (rx_needs_csum || r_gso_ok);
    r_flags[NPH_FLAG_DATA_VALID] = feat_guest_csum && rx_data_valid;
    r_cst  = rx_csum_start;
    r_cofs = rx_csum_offset;
    if (feat_rsc_ext && r_gso_ok) begin
      r_flags[NPH_FLAG_RSC_INFO] = 1'b1;
      r_cst  = rx_coalesced;
      r_cofs = rx_dup_acks;
    end
    r_nbuf = feat_mrg_rxbuf ? rx_buf_count : NPH_ONE_BUF;

    rxh_d    = rxh_q;
    rx_idx_d = rx_idx_q;
    busy_d   = rx_busy;
    rvalid_d = 1'b0;
    rlast_d  = 1'b0;
    rbyte_d  = rx_hdr_byte;
    if (rx_busy) begin
      rvalid_d = 1'b1;
      rbyte_d  = rxh_q[rx_idx_q];
      rx_idx_d = rx_idx_q + 4'h1;
      if (rx_idx_q == NPH_HDR_LAST) begin
        rlast_d  = 1'b1;
        busy_d   = 1'b0;
        rx_idx_d = 4'h0;
      end
    end else if (rx_start) begin
      busy_d = 1'b1;
      rxh_d[NPH_OFS_FLAGS]           = r_flags;
      rxh_d[NPH_OFS_GSO_TYPE]        = r_gso;
      rxh_d[NPH_OFS_HDR_LEN]         = rx_hdr_len[7:0];
      rxh_d[NPH_OFS_HDR_LEN + 4'h1]  = rx_hdr_len[15:8];
      rxh_d[NPH_OFS_GSO_SIZE]        = r_gso_ok ? rx_gso_size[7:0] : 8'h00;
      rxh_d[NPH_OFS_GSO_SIZE + 4'h1] = r_gso_ok ? rx_gso_size[15:8] : 8'h00;
      rxh_d[NPH_OFS_CSUM_ST]         = r_cst[7:0];
      rxh_d[NPH_OFS_CSUM_ST + 4'h1]  = r_cst[15:8];
      rxh_d[NPH_OFS_CSUM_OFS]        = r_cofs[7:0];
      rxh_d[NPH_OFS_CSUM_OFS + 4'h1] = r_cofs[15:8];
      rxh_d[NPH_OFS_NUM_BUFS]        = r_nbuf[7:0];
      rxh_d[NPH_OFS_NUM_BUFS + 4'h1] = r_nbuf[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxh_q        <= '{default: 8'h00};
      rx_idx_q     <= 4'h0;
      rx_busy      <= 1'b0;
      rx_hdr_valid <= 1'b0;
      rx_hdr_last  <= 1'b0;
      rx_hdr_byte  <= 8'h00;
    end else if (ce) begin
      rxh_q        <= rxh_d;
      rx_idx_q     <= rx_idx_d;
      rx_busy      <= busy_d;
      rx_hdr_valid <= rvalid_d;
      rx_hdr_last  <= rlast_d;
      rx_hdr_byte  <= rbyte_d;
    end
  end
endmodule : nph_top
`default_nettype wire

// ==== nph_top_props.sv ====
// assertion checker for the packet header offload block ports
`timescale 1ns/1ps
`default_nettype none
module nph_top_props
  import nph_pkg::*;
#(
  parameter logic [15:0] MAX_HDR_LEN = NPH_MAX_HDR_LEN  // hdr_len guard ceiling
) (
  input wire logic        clk_sys,          // clock
  input wire logic        sys_rst,          // sync reset
  input wire logic        feat_hdrlen,      // exact header length
  input wire logic        feat_mrg_rxbuf,   // mergeable buffers
  input wire logic        tx_hdr_valid,     // header decoded
  input wire logic        tx_needs_csum,    // checksum to fill
  input wire logic        tx_csum_ok,       // checksum trusted
  input wire logic [7:0]  tx_gso_type,      // gso code
  input wire logic [15:0] tx_hdr_len,       // header length
  input wire logic        tx_hdr_len_exact, // hdr_len trusted
  input wire logic        tx_csum_done,     // checksum ready
  input wire logic        rx_start,         // build request
  input wire logic [15:0] rx_buf_count,     // buffers used
  input wire logic        rx_busy,          // emitting
  input wire logic        rx_hdr_valid,     // byte present
  input wire logic [7:0]  rx_hdr_byte,      // header byte
  input wire logic        rx_hdr_last       // last byte
);
  logic [3:0] rx_idx_q;
  logic [3:0] rx_idx_d;
  // byte position inside the emitted header, restarts after the last byte
  always_comb begin
    rx_idx_d = rx_idx_q;
    if (rx_hdr_valid) begin
      rx_idx_d = rx_hdr_last ? 4'h0 : rx_idx_q + 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    rx_idx_q <= sys_rst ? 4'h0 : rx_idx_d;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_rx_take;
    rx_start && !rx_busy;
  endsequence
  sequence s_rx_bytes;
    (rx_hdr_valid && !rx_hdr_last)[*8] ##1 (rx_hdr_valid && !rx_hdr_last)[*3]
    ##1 (rx_hdr_valid && rx_hdr_last);
  endsequence
  property p_rx_frame;
    s_rx_take |=> rx_busy ##1 s_rx_bytes;
  endproperty
  property p_exact_guard;
    tx_hdr_len_exact |-> (tx_hdr_len >= NPH_MIN_HDR_LEN) && (tx_hdr_len <= MAX_HDR_LEN)
      && (tx_gso_type[6:0] != NPH_GSO_NONE);
  endproperty
  property p_hint_only;
    tx_hdr_valid && !feat_hdrlen |-> !tx_hdr_len_exact;
  endproperty
  property p_done_needs;
    tx_csum_done |-> tx_needs_csum && tx_csum_ok;
  endproperty
  property p_nocsum_untrusted;
    tx_hdr_valid && !tx_needs_csum |-> !tx_csum_ok;
  endproperty
  property p_nocsum_nodone;
    tx_hdr_valid && !tx_needs_csum |-> (!tx_csum_done)[*8];
  endproperty
  property p_one_buf;
    rx_hdr_valid && rx_idx_q == NPH_OFS_NUM_BUFS && !feat_mrg_rxbuf
      |-> rx_hdr_byte == NPH_ONE_BUF[7:0] ##1 rx_hdr_byte == NPH_ONE_BUF[15:8];
  endproperty
  property p_buf_count;
    rx_hdr_valid && rx_idx_q == NPH_OFS_NUM_BUFS && feat_mrg_rxbuf
      |-> rx_hdr_byte == rx_buf_count[7:0]
      ##1 rx_hdr_byte == rx_buf_count[15:8];
  endproperty
  a_rx_frame: assert property (p_rx_frame) else $error("rx header framing wrong");
  a_exact_guard: assert property (p_exact_guard) else $error("bad hdr_len trusted");
  a_hint_only: assert property (p_hint_only) else $error("hint hdr_len trusted");
  a_done_needs: assert property (p_done_needs) else $error("stray checksum done");
  a_nocsum_untrusted: assert property (p_nocsum_untrusted) else $error("csum ok");
  a_nocsum_nodone: assert property (p_nocsum_nodone) else $error("csum fields used");
  a_one_buf: assert property (p_one_buf) else $error("num_buffers not one");
  a_buf_count: assert property (p_buf_count) else $error("num_buffers wrong");
endmodule : nph_top_props
`default_nettype wire
